//--- logic/spr_pkg.sv
/*
  Constants and carrier types for the slave parameter reader.
  Assumes one clock and that every user of these names qualifies them with the package name.
*/
package spr_pkg;

  // Legal station addresses on the network.
  localparam logic [7:0]  ADDR_MIN = 8'h01;
  localparam logic [7:0]  ADDR_MAX = 8'h7F;

  // Data width codes reported with a finished read.
  localparam logic [7:0]  WIDTH_BYTE  = 8'h01;
  localparam logic [7:0]  WIDTH_WORD  = 8'h02;
  localparam logic [7:0]  WIDTH_DWORD = 8'h04;
  localparam logic [7:0]  WIDTH_NONE  = 8'h00;

  // Error codes raised by the block itself; the network may supply others.
  localparam logic [15:0] ERR_NONE  = 16'h0000;
  localparam logic [15:0] ERR_ADDR  = 16'h0001;
  localparam logic [15:0] ERR_WIDTH = 16'h0002;
  localparam logic [15:0] ERR_SLAVE = 16'h0003;

  // Reset values of the result registers.
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

  // Offset added to a servo parameter number to form its index.
  localparam logic [15:0] SERVO_INDEX_BASE = 16'h2000;
  localparam logic [7:0]  SERVO_SUBINDEX   = 8'h00;

  // Handshake phases.
  typedef enum logic [1:0] {
    SPR_IDLE,
    SPR_WAIT,
    SPR_HOLD
  } spr_state_t;

  // One read request towards the network.
  typedef struct packed {
    logic [7:0]  station;
    logic [15:0] index;
    logic [7:0]  subindex;
  } spr_req_t;

  // One answer from the network.
  typedef struct packed {
    logic        fail;
    logic [15:0] code;
    logic [7:0]  width;
    logic [31:0] data;
  } spr_rsp_t;

  // Whole state of the reader.
  typedef struct packed {
    spr_state_t  state;
    logic        exec_prev;
    logic        done;
    logic        busy;
    logic        active;
    logic        error;
    logic [15:0] error_code;
    logic [7:0]  data_width_code;
    logic [31:0] data;
    logic        req_valid;
    spr_req_t    req;
  } spr_regs_t;

endpackage

//--- logic/spr_slave_parameter_reader.sv
/*
  Slave parameter reader: takes a station, index and subindex on a rising execute,
  issues one read to the network and reports done, busy, active, error and the value.
  Assumes the controller inputs and the network answer share clk, and that the
  network answers only after a request and at most once per request.
*/
`timescale 1ns/10ps

// Behaviour
// R01: Requester gives station 1 to 127.
// R02: Index and subindex sampled on execute rising.
// R03: Done set on finish, cleared by execute falling.
// R04: Busy from trigger until done or error.
// R05: Active from trigger until done or error.
// R06: Error on failure or illegal input; cleared on fall.
// R07: Error code valid while error set.
// R08: Width code 1, 2 or 4 bytes.
// R09: Thirty-two bit value after completion.
// R10: Servo index is number plus 2000h, subindex 0.
// R11: Busy on edge, done next answer cycle.
// R12: Results kept on fall, zeroed on error.
// R13: Illegal station errors; fall clears code.
// R14: Only false-to-true execute starts a read.
module spr_slave_parameter_reader (
  // Clock and reset.
  input  wire logic            clk,
  input  wire logic            nrst,
  // Request from the controller program.
  input  wire logic            execute,
  input  wire spr_pkg::spr_req_t request,
  // Status and result towards the controller program.
  output logic                 done,
  output logic                 busy,
  output logic                 active,
  output logic                 error,
  output logic [15:0]          error_code,
  output logic [7:0]           data_width_code,
  output logic [31:0]          data,
  // Read towards the network.
  output logic                 net_req_valid,
  output spr_pkg::spr_req_t    net_req,
  // Answer from the network.
  input  wire logic            net_rsp_valid,
  input  wire spr_pkg::spr_rsp_t net_rsp
);

  spr_pkg::spr_regs_t s;
  spr_pkg::spr_regs_t next_s;
  logic               rise;

  // True when a station address lies inside the legal range.
  function automatic logic station_ok(input logic [7:0] st);
    station_ok = (st >= spr_pkg::ADDR_MIN) && (st <= spr_pkg::ADDR_MAX);
  endfunction

  // True when the slave reports one of the three legal widths.
  function automatic logic width_ok(input logic [7:0] w);
    width_ok = (w == spr_pkg::WIDTH_BYTE) || (w == spr_pkg::WIDTH_WORD)
            || (w == spr_pkg::WIDTH_DWORD);
  endfunction

  // A held-high execute never starts a second read; only a fresh edge does.
  assign rise = execute && !s.exec_prev; // R14

  // Next-state logic of the whole handshake.
  always_comb begin
    next_s           = s;
    next_s.exec_prev = execute;
    next_s.req_valid = 1'b0;
    case (s.state)
      spr_pkg::SPR_IDLE: begin
        if (rise) begin
          if (!station_ok(request.station)) begin // R13
            next_s.error           = 1'b1; // R06
            next_s.error_code      = spr_pkg::ERR_ADDR; // R07
            next_s.data_width_code = spr_pkg::WIDTH_NONE; // R12
            next_s.data            = spr_pkg::DATA_RESET; // R12
            next_s.state           = spr_pkg::SPR_HOLD;
          end else begin
            next_s.busy      = 1'b1; // R04
            next_s.active    = 1'b1; // R05
            next_s.req       = request; // R02
            next_s.req_valid = 1'b1; // R11
            next_s.state     = spr_pkg::SPR_WAIT;
          end
        end
      end
      spr_pkg::SPR_WAIT: begin
        // A bad width is treated as a failed read so stale data is never shown.
        if (net_rsp_valid) begin
          next_s.busy   = 1'b0; // R04
          next_s.active = 1'b0; // R05
          next_s.state  = spr_pkg::SPR_HOLD;
          if (net_rsp.fail || !width_ok(net_rsp.width)) begin
            next_s.error           = 1'b1; // R06
            next_s.error_code      = net_rsp.fail ?
                                     ((net_rsp.code == spr_pkg::ERR_NONE) ?
                                      spr_pkg::ERR_SLAVE : net_rsp.code) :
                                     spr_pkg::ERR_WIDTH; // R07
            next_s.data_width_code = spr_pkg::WIDTH_NONE; // R12
            next_s.data            = spr_pkg::DATA_RESET; // R12
          end else begin
            next_s.done            = 1'b1; // R03
            next_s.data_width_code = net_rsp.width; // R08
            next_s.data            = net_rsp.data; // R09
          end
        end
      end
      spr_pkg::SPR_HOLD: begin
        // Results stay; only the flags and the code drop with execute.
        if (!execute) begin
          next_s.done       = 1'b0; // R03
          next_s.error      = 1'b0; // R06
          next_s.error_code = spr_pkg::ERR_NONE; // R13
          next_s.state      = spr_pkg::SPR_IDLE;
        end
      end
      default: begin
        next_s.state = spr_pkg::SPR_IDLE;
      end
    endcase
  end

  // State register; everything resets to idle and zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '{state: spr_pkg::SPR_IDLE, exec_prev: 1'b0, done: 1'b0, busy: 1'b0,
             active: 1'b0, error: 1'b0, error_code: spr_pkg::ERR_NONE,
             data_width_code: spr_pkg::WIDTH_NONE, data: spr_pkg::DATA_RESET,
             req_valid: 1'b0, req: '0};
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register.
  assign done            = s.done;
  assign busy            = s.busy;
  assign active          = s.active;
  assign error           = s.error;
  assign error_code      = s.error_code;
  assign data_width_code = s.data_width_code;
  assign data            = s.data;
  assign net_req_valid   = s.req_valid;
  assign net_req         = s.req;

  // Checks of the handshake.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_start_legal_read: assert property ( // R11
    (s.state == spr_pkg::SPR_IDLE) && rise && station_ok(request.station)
    |=> busy && active && net_req_valid && (net_req == $past(request)))
    else $error("legal trigger did not start a read");

  a_illegal_station: assert property ( // R13
    (s.state == spr_pkg::SPR_IDLE) && rise && !station_ok(request.station)
    |=> error && !busy && (error_code == spr_pkg::ERR_ADDR))
    else $error("illegal station did not raise error");

  a_done_drops_busy: assert property ( // R04
    $rose(done) |-> !busy && !active && $past(busy) && $past(active))
    else $error("done rose without ending busy and active");

  a_error_zeroes: assert property ( // R12
    $rose(error) |-> !busy && !active && (data == 32'h0000_0000)
                     && (data_width_code == 8'h00))
    else $error("error rose with busy or stale data");

  a_fall_clears: assert property ( // R06
    (error || done) && !execute |=> !error && !done && (error_code == 16'h0000))
    else $error("execute fall did not clear flags and code");

  a_done_holds: assert property ( // R03
    done && execute |=> done)
    else $error("done dropped while execute high");

  a_result_kept: assert property ( // R12
    $fell(done) |-> $stable(data) && $stable(data_width_code))
    else $error("results changed when done fell");

  a_width_legal: assert property ( // R08
    done |-> width_ok(data_width_code))
    else $error("done with an illegal width code");

  a_answer_taken: assert property ( // R09
    (s.state == spr_pkg::SPR_WAIT) && net_rsp_valid && !net_rsp.fail
      && width_ok(net_rsp.width)
    |=> done && (data == $past(net_rsp.data)))
    else $error("answer not reported");

  a_code_idle: assert property ( // R07
    !error |-> (error_code == 16'h0000))
    else $error("error code set without error");

  a_no_restart: assert property ( // R14
    execute && $past(execute) && $past(nrst) && (s.state == spr_pkg::SPR_IDLE)
    |=> !net_req_valid)
    else $error("held execute started a read");

  a_active_busy: assert property ( // R05
    active == busy)
    else $error("active and busy disagree");

  a_busy_holds: assert property ( // R04
    busy && !net_rsp_valid |=> busy)
    else $error("busy dropped before the answer");

  a_req_one_pulse: assert property ( // R11
    net_req_valid |=> !net_req_valid)
    else $error("read request stood longer than one cycle");

  a_code_on_error: assert property ( // R07
    error |-> (error_code != 16'h0000))
    else $error("error set without a code");

  a_done_error_apart: assert property ( // R06
    !(done && error))
    else $error("done and error set together");

  a_refused_rise: assert property ( // R14
    rise && (s.state != spr_pkg::SPR_IDLE) |=> !net_req_valid && $stable(net_req))
    else $error("rise during a read started another");

endmodule // spr_slave_parameter_reader

//--- test/spr_net_slave_model.sv
/*
  Behavioural network slave that answers one parameter read per request.
  Assumes the reader pulses req_valid for one cycle and shares clk with this model.
*/
`timescale 1ns/10ps

module spr_net_slave_model (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              nrst,
  // Read request from the reader.
  input  wire logic              req_valid,
  input  wire spr_pkg::spr_req_t req,
  // Answer shape chosen by the bench.
  input  wire logic [3:0]        delay,
  input  wire logic              fail,
  input  wire logic [15:0]       code,
  input  wire logic [7:0]        width,
  // Answer towards the reader.
  output logic                   rsp_valid,
  output spr_pkg::spr_rsp_t      rsp
);
  logic        pend;
  logic [3:0]  cnt;
  logic [15:0] idx;

  // The value is built from the index so that each read is distinct.
  // Between answers the bus toggles, so a reader that samples it early sees garbage.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend      <= 1'b0;
      cnt       <= 4'h0;
      idx       <= 16'h0000;
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      rsp_valid <= 1'b0;
      rsp       <= ~rsp;
      if (req_valid) begin
        pend <= 1'b1;
        cnt  <= delay;
        idx  <= req.index;
      end else if (pend && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (pend) begin
        pend      <= 1'b0;
        rsp_valid <= 1'b1;
        rsp       <= {fail, code, width, idx, ~idx};
      end
    end
  end
endmodule // spr_net_slave_model

//--- test/tb.sv
/*
  Self-checking bench for the slave parameter reader.
  Assumes the network model answers each request once after its set delay.
*/
`timescale 1ns/10ps

module tb;
  // One read: station, parameter number, answer shape, expected error code.
  typedef struct packed {
    logic [7:0]  st;
    logic [15:0] par;
    logic [7:0]  w;
    logic        f;
    logic [15:0] c;
    logic [3:0]  d;
    logic [15:0] ec;
  } spr_row_t;

  logic clk, nrst, execute, done, busy, active, error, nrv, rv, m_fail;
  logic [15:0] error_code, m_code;
  logic [7:0]  dwc, m_width;
  logic [31:0] data, exp_data;
  logic [3:0]  m_delay;
  spr_pkg::spr_req_t request, net_req;
  spr_pkg::spr_rsp_t net_rsp;
  int miscompares, checks, i, k;
  spr_row_t rows[8] = '{
    '{8'h01, 16'h0137, 8'h02, 1'b0, 16'h0000, 4'h0, 16'h0000},
    '{8'h7F, 16'h060A, 8'h04, 1'b0, 16'h0000, 4'h3, 16'h0000},
    '{8'h05, 16'h0001, 8'h01, 1'b0, 16'h0000, 4'h1, 16'h0000},
    '{8'h00, 16'h0001, 8'h02, 1'b0, 16'h0000, 4'h0, 16'h0001},
    '{8'h80, 16'h0001, 8'h02, 1'b0, 16'h0000, 4'h0, 16'h0001},
    '{8'h09, 16'h0002, 8'h03, 1'b0, 16'h0000, 4'h0, 16'h0002},
    '{8'h09, 16'h0003, 8'h02, 1'b1, 16'h0000, 4'h2, 16'h0003},
    '{8'h09, 16'h0004, 8'h02, 1'b1, 16'h8123, 4'h0, 16'h8123}};

  spr_slave_parameter_reader i_spr_slave_parameter_reader (.clk(clk), .nrst(nrst),
    .execute(execute), .request(request), .done(done), .busy(busy), .active(active),
    .error(error), .error_code(error_code), .data_width_code(dwc), .data(data),
    .net_req_valid(nrv), .net_req(net_req), .net_rsp_valid(rv), .net_rsp(net_rsp));

  spr_net_slave_model i_spr_net_slave_model (.clk(clk), .nrst(nrst), .req_valid(nrv),
    .req(net_req), .delay(m_delay), .fail(m_fail), .code(m_code), .width(m_width),
    .rsp_valid(rv), .rsp(net_rsp));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk_flag(input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic chk_val(input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // One full handshake; hold keeps the trigger high to show it cannot restart.
  task automatic run(input spr_row_t r, input logic hold);
    logic ok;
    ok = (r.st >= spr_pkg::ADDR_MIN) && (r.st <= spr_pkg::ADDR_MAX);
    @(posedge clk);
    m_delay <= r.d;
    m_fail  <= r.f;
    m_code  <= r.c;
    m_width <= r.w;
    request <= '{r.st, spr_pkg::SERVO_INDEX_BASE + r.par, spr_pkg::SERVO_SUBINDEX};
    execute <= 1'b1;
    @(posedge clk);
    #1;
    chk_flag(ok, busy);
    chk_flag(ok, active);
    chk_flag(ok, nrv);
    chk_flag(!ok, error);
    if (ok) chk_val(32'(request), 32'(net_req));
    k = 0;
    while (!done && !error && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    exp_data = (r.ec == 16'h0000) ? {request.index, ~request.index} : 32'h0000_0000;
    chk_val(32'(r.ec), 32'(error_code));
    chk_flag(r.ec == 16'h0000, done);
    chk_flag(1'b0, busy);
    chk_flag(1'b0, active);
    chk_val((r.ec == 16'h0000) ? 32'(r.w) : 32'h0000_0000, 32'(dwc));
    chk_val(exp_data, data);
    repeat (hold ? 5 : 0) begin
      @(posedge clk);
      #1;
      chk_flag(1'b0, nrv);
      chk_flag(1'b1, done);
    end
    @(posedge clk);
    execute <= 1'b0;
    @(posedge clk);
    #1;
    chk_flag(1'b0, done);
    chk_flag(1'b0, error);
    chk_val(32'h0000_0000, 32'(error_code));
    chk_val(exp_data, data);
  endtask

  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Main sequence: reset, the table of reads, a held trigger, a refused rise, then a reset in mid-read.
  initial begin
    nrst = 1'b0;
    execute = 1'b0;
    request = '0;
    m_delay = 4'h0;
    m_fail = 1'b0;
    m_code = 16'h0000;
    m_width = 8'h00;
    @(posedge clk);
    #1;
    chk_flag(1'b0, done | busy | error | nrv);
    @(posedge clk);
    @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 8; i++) begin
      run(rows[i], 1'b0);
      $display("row %0d finished", i);
    end
    run(rows[1], 1'b1);
    $display("held trigger finished");
    // A rise while waiting is refused; a drop while waiting leaves done for one cycle.
    @(posedge clk);
    m_delay <= 4'h3;
    m_width <= spr_pkg::WIDTH_WORD;
    m_fail  <= 1'b0;
    request <= '{8'h11, spr_pkg::SERVO_INDEX_BASE + 16'h0155, spr_pkg::SERVO_SUBINDEX};
    execute <= 1'b1;
    @(posedge clk);
    execute <= 1'b0;
    @(posedge clk);
    execute <= 1'b1;
    @(posedge clk);
    execute <= 1'b0;
    #1;
    chk_flag(1'b0, nrv);
    chk_flag(1'b1, busy);
    k = 0;
    while (!done && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk_flag(1'b1, done);
    chk_val({16'h2155, ~16'h2155}, data);
    @(posedge clk);
    #1;
    chk_flag(1'b0, done);
    chk_val(32'h0000_0002, 32'(dwc));
    $display("refused rise finished");
    // Reset in mid-read: every result drops at once and the next read starts clean.
    @(posedge clk);
    execute <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    nrst <= 1'b0;
    execute <= 1'b0;
    #1;
    chk_flag(1'b0, busy | active | nrv);
    chk_val(32'h0000_0000, data | 32'(dwc));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    run(rows[2], 1'b0);
    $display("mid-run reset finished");
    complete_run;
  end

  // Watchdog well beyond the hundred or so cycles the tests need.
  initial begin
    #100000;
    miscompares++;
    complete_run;
  end
endmodule // tb
